/* File: core/comp1_defs.svh */
`ifndef COMP1_DEFS_SVH
`define COMP1_DEFS_SVH

// ==========================================================
// Register offsets on the plain register port
`define CTRL_ADDR 8'h00
`define IRQ_STATUS_ADDR 8'h01
`define IRQ_MASK_ADDR 8'h02

// ==========================================================
// Control register field positions
`define ENABLE_BIT 7
`define RESULT_BIT 6
`define PIN_DRIVE_BIT 5
`define INVERT_BIT 4
`define UNUSED_BIT 3
`define REF_SELECT_BIT 2
`define CHANNEL_HI 1
`define CHANNEL_LO 0

// Bits that software may write in the control register
`define CTRL_WRITE_MASK 8'hB7

// ==========================================================
// Interrupt status and mask field positions
`define IRQ_MISMATCH_BIT 0
`define IRQ_CHANGE_BIT 1
`define IRQ_WRITE_MASK 8'h03

// ==========================================================
// Reset values
`define CTRL_RESET 8'h00
`define IRQ_STATUS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

`endif

/* File: core/comp1_pkg.sv */
package comp1_pkg;

  // ==========================================================
  // Shared types
  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    neg_pin_0,
    neg_pin_1,
    neg_pin_2,
    neg_pin_3
  } neg_channel_t;

endpackage : comp1_pkg

/* File: core/comparator_one_control.sv */
// Notes on behaviour
// [R1] Bit 7 enables the comparator: one on, zero off.
// [R2] Bit 5 presents the result on the output pin when set.
// [R3] Pin driven only with pin drive, enable set and direction zero.
// [R4] Bit 2 picks internal reference when one, positive pin when zero.
// [R5] Bits 1-0 choose one of four shared negative pins.
// [R6] Bit 3 reads zero and ignores writes.
// [R7] Invert bit flips the reported result.
// [R8] The result is a read-only status bit of the control register.
// [R9] Every read or write captures the result into the mismatch latch; the code captures only on control register accesses.
// [R10] Reset returns the control register to zero, comparator off.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "comp1_defs.svh"

module comparator_one_control
  import comp1_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic comp1_raw,
  input wire logic pin_direction,
  output logic comp1_enable,
  output logic comp1_ref_select,
  output logic [3:0] comp1_neg_channel_sel,
  output logic comp1_pin_out,
  output logic comp1_pin_oe,
  output logic irq
);

  // ==========================================================
  // Helper functions

  // One-hot pin select from the channel code
  function automatic logic [3:0] channel_onehot(input neg_channel_t code);
    logic [3:0] sel;
    sel = 4'h0;
    case (code)
      neg_pin_0: begin
        sel = 4'h1;
      end
      neg_pin_1: begin
        sel = 4'h2;
      end
      neg_pin_2: begin
        sel = 4'h4;
      end
      default: begin
        sel = 4'h8;
      end
    endcase
    return sel;
  endfunction : channel_onehot

  // Address match with a strobe, used by every register
  function automatic logic hit(input logic stb, input logic [7:0] addr,
                               input logic [7:0] target);
    return stb && (addr == target);
  endfunction : hit

  // ==========================================================
  // Declarations

  reg_byte_t comparator_one_control;
  reg_byte_t next_comparator_one_control;
  reg_byte_t irq_status;
  reg_byte_t next_irq_status;
  reg_byte_t irq_mask;
  reg_byte_t next_irq_mask;
  reg_byte_t next_reg_rdata;
  reg_byte_t ctrl_view;
  logic raw_sync;
  logic comp1_result;
  logic ctrl_wr;
  logic ctrl_rd;
  logic status_wr;
  logic mask_wr;
  logic mismatch;
  logic mismatch_rise;
  logic result_change;
  logic comp1_invert;
  logic comp1_pin_drive;
  neg_channel_t comp1_neg_channel;

  // ==========================================================
  // Input crossing

  // The analog result arrives from outside the clock domain
  level_sync u_raw_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(comp1_raw),
    .sync_out(raw_sync)
  );

  // ==========================================================
  // Field views of the control register

  assign comp1_enable = comparator_one_control[`ENABLE_BIT]; // see [R1]
  assign comp1_pin_drive = comparator_one_control[`PIN_DRIVE_BIT];
  assign comp1_invert = comparator_one_control[`INVERT_BIT];
  assign comp1_ref_select = comparator_one_control[`REF_SELECT_BIT]; // see [R4]
  assign comp1_neg_channel =
    neg_channel_t'(comparator_one_control[`CHANNEL_HI:`CHANNEL_LO]);

  // Only one negative pin is steered to the inverting input at a time
  assign comp1_neg_channel_sel = channel_onehot(comp1_neg_channel); // see [R5]

  // ==========================================================
  // Result path

  // A disabled comparator reports zero; polarity applied before enable
  assign comp1_result = comp1_enable & (raw_sync ^ comp1_invert); // see [R7]

  // Pin drive needs all three conditions; unlatched like the raw output
  assign comp1_pin_oe = comp1_pin_drive & comp1_enable & ~pin_direction; // see [R2] [R3]
  assign comp1_pin_out = comp1_result; // see [R2]

  // ==========================================================
  // Bus decode

  assign ctrl_wr = hit(reg_wr, reg_addr, `CTRL_ADDR);
  assign ctrl_rd = hit(reg_rd, reg_addr, `CTRL_ADDR);
  assign status_wr = hit(reg_wr, reg_addr, `IRQ_STATUS_ADDR);
  assign mask_wr = hit(reg_wr, reg_addr, `IRQ_MASK_ADDR);

  // ==========================================================
  // Mismatch circuit

  // A write counts as a read too, so both refresh the latch
  mismatch_detect u_mismatch (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .result_now(comp1_result),
    .capture(ctrl_rd | ctrl_wr), // see [R9]
    .mismatch(mismatch),
    .mismatch_rise(mismatch_rise),
    .result_change(result_change)
  );

  // ==========================================================
  // Control register

  // Result bit and bit 3 are not stored; only writable bits load
  always_comb begin
    next_comparator_one_control = comparator_one_control;
    if (sys_rst) begin
      next_comparator_one_control = `CTRL_RESET; // see [R10]
    end else if (clk_en && ctrl_wr) begin
      next_comparator_one_control = reg_wdata & `CTRL_WRITE_MASK; // see [R6]
    end
  end

  always_ff @(posedge mclk) begin
    comparator_one_control <= next_comparator_one_control;
  end

  // ==========================================================
  // Interrupt status and mask

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (sys_rst) begin
      next_irq_status = `IRQ_STATUS_RESET;
      next_irq_mask = `IRQ_MASK_RESET;
    end else if (clk_en) begin
      if (status_wr) begin
        next_irq_status = irq_status & ~(reg_wdata & `IRQ_WRITE_MASK);
      end
      if (mask_wr) begin
        next_irq_mask = reg_wdata & `IRQ_WRITE_MASK;
      end
      if (mismatch_rise) begin
        next_irq_status[`IRQ_MISMATCH_BIT] = 1'b1;
      end
      if (result_change) begin
        next_irq_status[`IRQ_CHANGE_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    irq_status <= next_irq_status;
    irq_mask <= next_irq_mask;
  end

  // Level output, high while any unmasked flag stands
  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Read path

  // Result inserted live; unused bit 3 forced to zero
  always_comb begin
    ctrl_view = comparator_one_control & `CTRL_WRITE_MASK; // see [R6]
    ctrl_view[`RESULT_BIT] = comp1_result; // see [R8]
  end

  // Data stand the cycle after the strobe and hold while clk_en is low; unmapped reads zero
  always_comb begin
    next_reg_rdata = 8'h00;
    if (sys_rst) begin
      next_reg_rdata = 8'h00;
    end else if (!clk_en) begin
      next_reg_rdata = reg_rdata;
    end else if (reg_rd) begin
      case (reg_addr)
        `CTRL_ADDR: begin
          next_reg_rdata = ctrl_view;
        end
        `IRQ_STATUS_ADDR: begin
          next_reg_rdata = irq_status;
        end
        `IRQ_MASK_ADDR: begin
          next_reg_rdata = irq_mask;
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    reg_rdata <= next_reg_rdata;
  end

endmodule : comparator_one_control

/* File: core/level_sync.sv */
`timescale 1ns/1ns

// ==========================================================
// Two-stage synchroniser for an asynchronous level
module level_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);

  logic stage_one;
  logic next_stage_one;
  logic next_sync_out;

  // Stage one is read by stage two only
  always_comb begin
    next_stage_one = stage_one;
    next_sync_out = sync_out;
    if (sys_rst) begin
      next_stage_one = 1'b0;
      next_sync_out = 1'b0;
    end else if (clk_en) begin
      next_stage_one = async_in;
      next_sync_out = stage_one;
    end
  end

  always_ff @(posedge mclk) begin
    stage_one <= next_stage_one;
    sync_out <= next_sync_out;
  end

endmodule : level_sync

/* File: core/mismatch_detect.sv */
`timescale 1ns/1ns

// ==========================================================
// Two-latch mismatch circuit with edge event output
module mismatch_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic result_now,
  input wire logic capture,
  output logic mismatch,
  output logic mismatch_rise,
  output logic result_change
);

  logic read_latch;
  logic cycle_latch;
  logic mismatch_q;
  logic next_read_latch;
  logic next_cycle_latch;
  logic next_mismatch_q;

  // Mismatch is the xor of the two latches
  assign mismatch = read_latch ^ cycle_latch;
  // Edge, not level, raises the event so a flag clear needs no reread
  assign mismatch_rise = mismatch & ~mismatch_q;
  assign result_change = result_now ^ cycle_latch;

  // Read latch follows captures, cycle latch follows every cycle
  always_comb begin
    next_read_latch = read_latch;
    next_cycle_latch = cycle_latch;
    next_mismatch_q = mismatch_q;
    if (sys_rst) begin
      next_read_latch = 1'b0;
      next_cycle_latch = 1'b0;
      next_mismatch_q = 1'b0;
    end else if (clk_en) begin
      next_cycle_latch = result_now;
      next_mismatch_q = mismatch;
      if (capture) begin
        next_read_latch = result_now; // see [R9]
      end
    end
  end

  always_ff @(posedge mclk) begin
    read_latch <= next_read_latch;
    cycle_latch <= next_cycle_latch;
    mismatch_q <= next_mismatch_q;
  end

endmodule : mismatch_detect

/* File: dv/comp1_ctrl_checker.sv */
`timescale 1ns/1ns

// ==========================================================
// Port checks for the comparator control block
module comp1_ctrl_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic comp1_raw,
  input wire logic pin_direction,
  input wire logic comp1_enable,
  input wire logic comp1_ref_select,
  input wire logic [3:0] comp1_neg_channel_sel,
  input wire logic comp1_pin_out,
  input wire logic comp1_pin_oe,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic ctrl_wr;
  logic ctrl_rd;

  // Accepted accesses to the control register
  assign ctrl_wr = clk_en && reg_wr && reg_addr == 8'h00;
  assign ctrl_rd = clk_en && reg_rd && reg_addr == 8'h00;

  a_oe_needs_enable:
    assert property (comp1_pin_oe |-> comp1_enable && !pin_direction) else $error("pin drive bad");
  a_enable_follows:
    assert property (ctrl_wr |=> comp1_enable == $past(reg_wdata[7])) else $error("enable bad");
  a_ref_follows:
    assert property (ctrl_wr |=> comp1_ref_select == $past(reg_wdata[2])) else $error("ref bad");
  a_channel_decode:
    assert property (ctrl_wr |=> comp1_neg_channel_sel == (4'h1 << $past(reg_wdata[1:0])))
      else $error("channel bad");
  a_unused_zero:
    assert property (ctrl_rd |=> !reg_rdata[3]) else $error("bit three set");
  a_result_off:
    assert property (ctrl_rd && !comp1_enable |=> !reg_rdata[6]) else $error("result while off");
  a_rdata_idle:
    assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00) else $error("rdata not idle");
  a_reset_clears:
    assert property (disable iff (1'b0) sys_rst && clk_en |=> !comp1_enable && !comp1_pin_oe
      && comp1_neg_channel_sel == 4'h1 && !irq) else $error("reset state bad");
endmodule : comp1_ctrl_checker

bind comparator_one_control comp1_ctrl_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp1_raw(comp1_raw),
  .pin_direction(pin_direction), .comp1_enable(comp1_enable),
  .comp1_ref_select(comp1_ref_select), .comp1_neg_channel_sel(comp1_neg_channel_sel),
  .comp1_pin_out(comp1_pin_out), .comp1_pin_oe(comp1_pin_oe), .irq(irq));

/* File: dv/comparator_one_control_tb.sv */
`timescale 1ns/1ns

// ==========================================================
// Register-level bench for the comparator control block
module comparator_one_control_tb;
  logic mclk;
  logic sys_rst;
  logic clk_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic comp1_raw;
  logic pin_direction;
  logic comp1_enable;
  logic comp1_ref_select;
  logic [3:0] comp1_neg_channel_sel;
  logic comp1_pin_out;
  logic comp1_pin_oe;
  logic irq;
  int failures;
  int checks_done;

  comparator_one_control uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .comp1_raw(comp1_raw), .pin_direction(pin_direction),
    .comp1_enable(comp1_enable), .comp1_ref_select(comp1_ref_select),
    .comp1_neg_channel_sel(comp1_neg_channel_sel), .comp1_pin_out(comp1_pin_out),
    .comp1_pin_oe(comp1_pin_oe), .irq(irq));

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Write lands at the strobe edge; #1 lets it settle before any compare
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc

  // Covers the two-flop sync plus the latch and status stages
  task automatic settle;
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle

  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    print_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    comp1_raw = 1'b0;
    pin_direction = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk(8'(comp1_neg_channel_sel), 8'h01);
    rdc(8'h00, 8'h00);
    rdc(8'h10, 8'h00);
    wr(8'h00, 8'h48);
    rdc(8'h00, 8'h00);
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'hF7);
    chk(8'({comp1_ref_select, comp1_pin_oe, comp1_pin_out}), 8'h07);
    @(posedge mclk);
    pin_direction <= 1'b1;
    #1;
    chk(8'(comp1_pin_oe), 8'h00);
    @(posedge mclk);
    pin_direction <= 1'b0;
    // Every channel code; ref select stays at the pin
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h80 | 8'(i));
      chk(8'({comp1_ref_select, comp1_neg_channel_sel}), 8'h01 << i);
    end
    @(posedge mclk);
    comp1_raw <= 1'b1;
    settle;
    rdc(8'h00, 8'hC3);
    wr(8'h02, 8'h01);
    wr(8'h01, 8'h03);
    rdc(8'h01, 8'h00);
    @(posedge mclk);
    comp1_raw <= 1'b0;
    settle;
    chk(8'(irq), 8'h01);
    rdc(8'h01, 8'h03);
    wr(8'h01, 8'h03);
    chk(8'(irq), 8'h00);
    // The write must recapture the latch, or no new mismatch appears
    wr(8'h00, 8'h83);
    @(posedge mclk);
    comp1_raw <= 1'b1;
    settle;
    chk(8'(irq), 8'h01);
    wr(8'h02, 8'h00);
    chk(8'(irq), 8'h00);
    wr(8'h00, 8'h20);
    chk(8'({comp1_enable, comp1_pin_oe}), 8'h00);
    wr(8'h00, 8'hB3);
    // Clock enable low must freeze the register against a write
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(8'h00, 8'h00);
    @(posedge mclk);
    clk_en <= 1'b1;
    #1;
    chk(8'({comp1_enable, comp1_ref_select}), 8'h02);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdc(8'h00, 8'h00);
    chk(8'(comp1_neg_channel_sel), 8'h01);
    print_verdict;
  end
endmodule : comparator_one_control_tb
